// ==== logic/pipe_busy_track.sv ====
// per-pipe busy flag and end-of-transfer auto nak request
// assumes engine event pulses on core_clk
`timescale 1ns/1ps
module pipe_busy_track (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic txn_start,
	input  wire logic txn_done,
	input  wire logic short_rx,
	input  wire logic count_rx,
	input  wire logic auto_nak_en,
	output logic      busy_q,
	output logic      force_nak_q
);
	wire end_of_rx = short_rx | count_rx;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_q      <= 1'b0;
			force_nak_q <= 1'b0;
		end else begin
			busy_q      <= txn_start | (busy_q & ~txn_done);
			force_nak_q <= end_of_rx & auto_nak_en;
		end
	end
endmodule // pipe_busy_track

// ==== logic/pipe_store.sv ====
// small per-pipe register store, registered read data
// assumes one writer and one reader on core_clk
`timescale 1ns/1ps
module pipe_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic      [WIDTH-1:0]         rd_data_q,
	output logic      [DEPTH*WIDTH-1:0]   all_q
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= INIT;
			end
			rd_data_q <= INIT;
		end else begin
			if (wr_en) begin
				mem_q[wr_idx] <= wr_data;
			end
			rd_data_q <= (wr_en && wr_idx == rd_idx) ? wr_data : mem_q[rd_idx];
		end
	end

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			all_q[i*WIDTH +: WIDTH] = mem_q[i];
		end
	end
endmodule // pipe_store

// ==== logic/pipe_window_bank.sv ====
// windowed configuration bank for pipes 4 to 7, avalon-mm slave
// assumes the transaction engine on core_clk drives the event inputs
// Operation
// - window select is four bits; zero means none, four to seven pick pipes.
// - window accesses reach the storage of the pipe chosen by window select.
// - with no pipe chosen, windows and control read zero, writes ignored.
// - control registers are addressed directly, but read zero and ignore writes unless window select picks a pipe.
// - unassigned bits always read zero.
// - endpoint number in bits 3..0; zero marks the pipe unused.
// - direction bit 4: clear receives, set transmits.
// - auto nak bit 7 on receiving pipe 4 or 5 forces nak at end.
// - transfer ends on good short packet or full counted packets.
// - buffer mode bit 9 picks single or double, only for pipes 4, 5.
// - ready timing bit on receive: ready after readout, blocked until buffer clear.
// - ready timing bit on transmit suppresses the buffer ready event.
// - type bits 15..14: pipes 4,5 bulk 01; pipes 6,7 interrupt 10.
// - max packet 8..64 for pipes 4,5 (bits 6..3); 1..64 for 6,7; not clamped, writes keep 0..120 and 0..127.
// - max packet reads zero unselected, 0040h reset when a pipe is selected.
// - device select bits 15..12 use codes 0..5 only.
// - response code 00 nak, 01 buf, 1x stall; stall leaves through nak; a control write sets any code, stall to buf included.
// - busy flag rises at transaction start, falls when that transaction completes.
`timescale 1ns/1ps
`include "pipe_window_defs.svh"
module pipe_window_bank #(
	parameter int NUM_PIPES = 4
) (
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic [15:0]          address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [31:0]          writedata,
	input  wire logic [3:0]           byteenable,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	output logic      [1:0]           response,
	input  wire logic [NUM_PIPES-1:0] txn_start,
	input  wire logic [NUM_PIPES-1:0] txn_done,
	input  wire logic [NUM_PIPES-1:0] short_rx,
	input  wire logic [NUM_PIPES-1:0] count_rx,
	input  wire logic [NUM_PIPES-1:0] packet_read,
	input  wire logic [NUM_PIPES-1:0] packet_moved,
	output logic      [NUM_PIPES-1:0] buffer_ready_q,
	output logic      [NUM_PIPES-1:0] rx_blocked_q,
	output logic      [NUM_PIPES-1:0] double_buf_q,
	output logic      [NUM_PIPES*2-1:0] resp_code_q,
	output logic      [NUM_PIPES*16-1:0] cfg_out_q
);
	import pipe_window_pkg::*;

	// ****************************************
	// bus decode
	// ****************************************
	bus_state_t       state_q;
	logic [3:0]       sel_q;
	logic [31:0]      rdata_q;
	logic [NUM_PIPES*2-1:0] resp_q;
	logic [NUM_PIPES-1:0]   abc_q;
	logic [NUM_PIPES-1:0]   busy;
	logic [NUM_PIPES-1:0]   force_nak;
	logic [NUM_PIPES-1:0]   blocked_q;
	logic [15:0]      cfg_rd;
	logic [15:0]      maxp_rd;
	logic [15:0]      ivl_rd;
	logic [NUM_PIPES*16-1:0] cfg_all;
	logic [NUM_PIPES*16-1:0] maxp_all;

	function automatic logic is_pipe(input logic [3:0] s);
		return s[3:2] == 2'b01;
	endfunction

	function automatic logic [15:0] legal_maxp(input logic [15:0] d, input logic bulk);
		logic [3:0] dev;
		dev = (d[15:12] > `TARGET_DEVICE_SELECT_MAX) ? 4'h0 : d[15:12];
		if (bulk) begin
			return {dev, 5'h00, d[6:3], 3'h0};
		end
		return {dev, 5'h00, d[6:0]};
	endfunction

	// no new take at the answer edge, while the master still holds its request
	wire        req      = (read | write) && state_q == bus_idle && waitrequest;
	wire        wr_req   = write && state_q == bus_idle && waitrequest;
	wire        full_lo  = byteenable[1:0] == 2'b11;
	wire        sel_ok   = is_pipe(sel_q);
	wire [1:0]  win_idx  = sel_q[1:0];
	wire        hit_sel  = address == `OFS_WINDOW_SELECT;
	wire        hit_cfg  = address == `OFS_PIPE_CFG;
	wire        hit_maxp = address == `OFS_PIPE_MAXP;
	wire        hit_ivl  = address == `OFS_PIPE_INTERVAL;
	wire        hit_ctrl = address[15:4] == 12'(`OFS_PIPE_CTRL_BASE >> 4) && address[1:0] == 2'b00;
	wire [1:0]  ctrl_idx = address[3:2];
	wire        hit_evt  = address == `OFS_PIPE_EVENT;
	wire        hit_any  = hit_sel | hit_cfg | hit_maxp | hit_ivl | hit_ctrl | hit_evt;
	wire        bulk_sel = ~win_idx[1];
	// writes to windows ignored with no pipe chosen
	wire        wr_cfg   = wr_req & full_lo & hit_cfg & sel_ok;
	wire        wr_maxp  = wr_req & full_lo & hit_maxp & sel_ok;
	wire        wr_ivl   = wr_req & full_lo & hit_ivl & sel_ok & win_idx[1];
	// control decoded from the address alone; the write lands only while a pipe is chosen
	wire        wr_ctrl  = wr_req & byteenable[0] & hit_ctrl;
	wire        wr_evt   = wr_req & byteenable[0] & hit_evt;
	// reserved bits masked to zero
	wire [15:0] cfg_wd   = writedata[15:0] & `CFG_MASK;
	wire [15:0] maxp_wd  = legal_maxp(writedata[15:0], bulk_sel);

	pipe_store #(.WIDTH(16), .DEPTH(NUM_PIPES), .INIT(16'h0000)) cfg_store (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.wr_en    (wr_cfg),
		.wr_idx   (win_idx),
		.wr_data  (cfg_wd),
		.rd_idx   (win_idx),
		.rd_data_q(cfg_rd),
		.all_q    (cfg_all)
	);

	pipe_store #(.WIDTH(16), .DEPTH(NUM_PIPES), .INIT({7'h00, `MAXP_RESET})) maxp_store (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.wr_en    (wr_maxp),
		.wr_idx   (win_idx),
		.wr_data  (maxp_wd),
		.rd_idx   (win_idx),
		.rd_data_q(maxp_rd),
		.all_q    (maxp_all)
	);

	pipe_store #(.WIDTH(16), .DEPTH(NUM_PIPES), .INIT(16'h0000)) ivl_store (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.wr_en    (wr_ivl),
		.wr_idx   (win_idx),
		.wr_data  (writedata[15:0] & `INTERVAL_MASK),
		.rd_idx   (win_idx),
		.rd_data_q(ivl_rd),
		.all_q    ()
	);

	function automatic logic ctrl_idx_evt(input int p);
		return writedata[11:8] == 4'(p) + `FIRST_PIPE;
	endfunction

	// ****************************************
	// per-pipe tracking
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NUM_PIPES; g++) begin : gen_pipe
			wire [15:0] c    = cfg_all[g*16 +: 16];
			wire        rx   = ~c[`CFG_DIR_BIT];
			wire        used = c[3:0] != 4'h0;
			wire        bulk = g < 2;
			wire        typ_ok = bulk ? c[15:14] == `TYPE_BULK : c[15:14] == `TYPE_INTR;
			wire        brt  = c[`CFG_BRT_BIT];
			pipe_busy_track trk (
				.core_clk   (core_clk),
				.sys_rst    (sys_rst),
				.txn_start  (txn_start[g]),
				.txn_done   (txn_done[g]),
				.short_rx   (short_rx[g]),
				.count_rx   (count_rx[g]),
				.auto_nak_en(bulk && rx && c[`CFG_NAK_BIT]),
				.busy_q     (busy[g]),
				.force_nak_q(force_nak[g])
			);
			wire clr_blk = wr_evt & writedata[`EVT_CLEAR_BIT] & ctrl_idx_evt(g);
			// ready event source picked by timing bit and direction
			wire rdy_ev = used & typ_ok & (brt ? (rx & packet_read[g]) : packet_moved[g]);
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					blocked_q[g]      <= 1'b0;
					buffer_ready_q[g] <= 1'b0;
					double_buf_q[g]   <= 1'b0;
				end else begin
					buffer_ready_q[g] <= rdy_ev;
					blocked_q[g]      <= (brt & rx & packet_read[g]) | (blocked_q[g] & ~clr_blk);
					double_buf_q[g]   <= bulk & c[`CFG_BUFMODE_BIT];
				end
			end
		end
	endgenerate

	// ****************************************
	// control registers and response codes
	// ****************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			resp_q <= '0;
			abc_q  <= '0;
			sel_q  <= `SEL_NONE;
		end else begin
			if (wr_req & byteenable[0] & hit_sel) begin
				sel_q <= writedata[3:0];
			end
			for (int i = 0; i < NUM_PIPES; i++) begin
				// hardware nak wins over a same-cycle software write
				if (force_nak[i]) begin
					resp_q[i*2 +: 2] <= `RESP_NAK;
				end else if (wr_ctrl && ctrl_idx == 2'(i) && sel_ok) begin
					resp_q[i*2 +: 2] <= writedata[1:0];
					abc_q[i]         <= writedata[9];
				end
			end
		end
	end

	// ****************************************
	// read mux and handshake
	// ****************************************
	wire [15:0] ctrl_rd = sel_ok ? {6'h00, abc_q[ctrl_idx], 3'h0, busy[ctrl_idx], 3'h0,
		resp_q[ctrl_idx*2 +: 2]} : 16'h0000;
	wire [15:0] evt_rd  = {12'h000, rx_blocked_q};

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q     <= bus_idle;
			waitrequest <= 1'b1;
			readdata    <= '0;
			response    <= 2'b00;
			rdata_q     <= '0;
		end else begin
			unique case (state_q)
				bus_idle: begin
					waitrequest <= 1'b1;
					if (req) begin
						state_q <= bus_done;
						response <= hit_any ? 2'b00 : 2'b10;
						rdata_q <= {16'h0000, hit_sel ? {12'h000, sel_q} : hit_ctrl ? ctrl_rd : hit_evt ? evt_rd : 16'h0000};
					end
				end
				bus_done: begin
					state_q     <= bus_idle;
					waitrequest <= 1'b0;
					readdata    <= !sel_ok ? rdata_q : hit_cfg ? {16'h0000, cfg_rd} :
						hit_maxp ? {16'h0000, maxp_rd} : hit_ivl ? {16'h0000, ivl_rd} : rdata_q;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_blocked_q <= '0;
			resp_code_q  <= '0;
			cfg_out_q    <= '0;
		end else begin
			rx_blocked_q <= blocked_q;
			resp_code_q  <= resp_q;
			cfg_out_q    <= cfg_all;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	unsel_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!waitrequest && read && !sel_ok && (hit_cfg || hit_maxp || hit_ivl)) |-> readdata == 32'h0)
		else $error("window read not zero with no pipe");
	busy_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		txn_start[3] |=> busy[3])
		else $error("busy did not rise");
	busy_fall_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(busy[3] && txn_done[3] && !txn_start[3]) |=> !busy[3])
		else $error("busy did not fall");
	auto_nak_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		force_nak[0] |=> resp_q[1:0] == 2'b00)
		else $error("auto nak not applied");
	tx_no_ready_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(cfg_all[26] && cfg_all[20]) |=> !buffer_ready_q[1])
		else $error("ready on transmit with timing bit");
	blocked_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(blocked_q[0] && !wr_evt) |=> blocked_q[0])
		else $error("block released without clear");
	sel_reserved_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!waitrequest && read && hit_sel) |-> readdata[31:4] == 28'h0)
		else $error("reserved bits nonzero");
	single_pipe6_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!double_buf_q[2])
		else $error("double buffer on pipe 6");
	bus_answer_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(req) |-> ##2 !waitrequest)
		else $error("no answer in two cycles");
endmodule // pipe_window_bank

// ==== logic/pipe_window_defs.svh ====
// offsets, field positions and reset values of the pipe window bank
// assumes a 16-bit avalon-mm byte address with one register per aligned word
`ifndef PIPE_WINDOW_DEFS_SVH
`define PIPE_WINDOW_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_WINDOW_SELECT   16'h2e64
`define OFS_PIPE_CFG        16'h2e68
`define OFS_PIPE_MAXP       16'h2f6c
`define OFS_PIPE_INTERVAL   16'h2e6c
`define OFS_PIPE_CTRL_BASE  16'h2e70
`define OFS_PIPE_EVENT      16'h2e80

// ****************************************
// field positions
// ****************************************
`define CFG_EP_LSB          0
`define CFG_DIR_BIT         4
`define CFG_NAK_BIT         7
`define CFG_BUFMODE_BIT     9
`define CFG_BRT_BIT         10
`define CFG_TYPE_LSB        14
`define CFG_MASK            16'hc69f
`define CTRL_MASK           16'h0203
`define INTERVAL_MASK       16'h0007
`define CTRL_BUSY_BIT       5
`define EVT_SHORT_BIT       0
`define EVT_COUNT_BIT       1
`define EVT_DONE_BIT        2
`define EVT_READ_BIT        3
`define EVT_CLEAR_BIT       4

// ****************************************
// reset values and codes
// ****************************************
`define MAXP_RESET          9'h040
`define SEL_NONE            4'h0
`define RESP_NAK            2'h0
`define RESP_BUF            2'h1
`define TYPE_BULK           2'h1
`define TYPE_INTR           2'h2
`define TARGET_DEVICE_SELECT_MAX          4'h5
`define FIRST_PIPE          4'h4

`endif

// ==== logic/pipe_window_pkg.sv ====
// types shared by the pipe window bank
// assumes the defs header for every number
package pipe_window_pkg;
	typedef enum logic [1:0] {
		bus_idle,
		bus_done
	} bus_state_t;
	typedef logic [1:0] pipe_idx_t;
endpackage

// ==== verif/usb_pipe_window_config_test.sv ====
// self-checking bench for the pipe window bank over avalon-mm
// assumes the defs header and package from logic/, one clock at 125 MHz
`timescale 1ns/1ps
`include "pipe_window_defs.svh"
module usb_pipe_window_config_test;
	import pipe_window_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic        core_clk = 1'b0;
	logic        sys_rst  = 1'b1;
	logic [15:0] address  = 16'h0;
	logic        read     = 1'b0;
	logic        write    = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'hf;
	logic [3:0]  txn_start = 4'h0, txn_done = 4'h0, short_rx = 4'h0;
	logic [3:0]  count_rx = 4'h0, packet_read = 4'h0, packet_moved = 4'h0;
	logic [31:0] readdata, got_d;
	logic        waitrequest;
	logic [1:0]  response, got_r;
	logic [3:0]  buffer_ready_q, rx_blocked_q, double_buf_q, dv;
	logic [7:0]  resp_code_q;
	logic [63:0] cfg_out_q;
	logic [15:0] cv, mv, me;
	int          err_count = 0, tests_run = 0, p, rdy0 = 0, rdy1 = 0, b0, b1;

	always #4 core_clk = ~core_clk;

	pipe_window_bank #(.NUM_PIPES(4)) u_pipe_window_bank (
		.core_clk(core_clk), .sys_rst(sys_rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .response(response),
		.txn_start(txn_start), .txn_done(txn_done), .short_rx(short_rx),
		.count_rx(count_rx), .packet_read(packet_read), .packet_moved(packet_moved),
		.buffer_ready_q(buffer_ready_q), .rx_blocked_q(rx_blocked_q),
		.double_buf_q(double_buf_q), .resp_code_q(resp_code_q), .cfg_out_q(cfg_out_q)
	);

	// counts ready pulses, latency free
	always @(posedge core_clk) begin
		if (buffer_ready_q[0] === 1'b1)
			rdy0++;
		if (buffer_ready_q[1] === 1'b1)
			rdy1++;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// holds the request until waitrequest is sampled low
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		address <= a;
		read <= ~w;
		write <= w;
		writedata <= d;
		do begin
			@(posedge core_clk);
			n++;
			if (n > 40) begin
				err_count++;
				test_done();
			end
		end while (waitrequest !== 1'b0);
		got_d = readdata;
		got_r = response;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask

	task automatic rc(input string nm, input logic [15:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(nm, e, got_d);
	endtask

	// one-cycle engine event on the chosen input
	task automatic pls(input int w, input logic [3:0] m);
		@(posedge core_clk);
		case (w)
			0: txn_start <= m;
			1: txn_done <= m;
			2: short_rx <= m;
			3: count_rx <= m;
			4: packet_read <= m;
			default: packet_moved <= m;
		endcase
		@(posedge core_clk);
		{txn_start, txn_done, short_rx, count_rx, packet_read, packet_moved} <= 24'h0;
	endtask

	task automatic set_exp(input int q);
		dv = 4'(q - 3);
		cv = {(q < 6) ? 2'b01 : 2'b10, 6'h3f, 4'hf, 4'(q)};
		mv = {dv, 12'hfff};
		me = {dv, 3'h0, (q < 6) ? 9'h078 : 9'h07f};
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		test_done();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		rc("select rst", `OFS_WINDOW_SELECT, 32'h0);
		rc("cfg none", `OFS_PIPE_CFG, 32'h0);
		rc("maxp none", `OFS_PIPE_MAXP, 32'h0);
		$display("test reset done");
		for (p = 4; p < 8; p++) begin
			wr(`OFS_WINDOW_SELECT, 32'(p));
			rc("cfg rst", `OFS_PIPE_CFG, 32'h0);
			rc("maxp rst", `OFS_PIPE_MAXP, 32'h40);
			set_exp(p);
			wr(`OFS_PIPE_CFG, {16'hffff, cv});
			wr(`OFS_PIPE_MAXP, {16'hffff, mv});
			wr(`OFS_PIPE_INTERVAL, 32'hffffffff);
		end
		for (p = 4; p < 8; p++) begin
			wr(`OFS_WINDOW_SELECT, 32'(p));
			set_exp(p);
			rc("cfg", `OFS_PIPE_CFG, {16'h0, cv & `CFG_MASK});
			rc("maxp", `OFS_PIPE_MAXP, {16'h0, me});
			rc("interval", `OFS_PIPE_INTERVAL, (p > 5) ? 32'h7 : 32'h0);
		end
		chk("double", 32'h3, {28'h0, double_buf_q});
		chk("cfg out", {16'h0, cv & `CFG_MASK}, {16'h0, cfg_out_q[63:48]});
		wr(`OFS_PIPE_MAXP, 32'h0000f040);
		rc("target_device_select bad", `OFS_PIPE_MAXP, 32'h40);
		wr(`OFS_PIPE_MAXP, 32'h00005040);
		rc("target_device_select 5", `OFS_PIPE_MAXP, 32'h5040);
		byteenable <= 4'h1;
		wr(`OFS_PIPE_MAXP, 32'h00000008);
		byteenable <= 4'hf;
		rc("maxp partial", `OFS_PIPE_MAXP, 32'h5040);
		$display("test windows done");
		wr(`OFS_WINDOW_SELECT, 32'h0);
		rc("cfg none", `OFS_PIPE_CFG, 32'h0);
		rc("maxp none", `OFS_PIPE_MAXP, 32'h0);
		rc("intv none", `OFS_PIPE_INTERVAL, 32'h0);
		wr(`OFS_PIPE_CTRL_BASE + 16'hc, 32'h1);
		wr(`OFS_PIPE_CFG, 32'h4004);
		wr(`OFS_WINDOW_SELECT, 32'hfffffff5);
		rc("select bits", `OFS_WINDOW_SELECT, 32'h5);
		set_exp(5);
		rc("cfg kept", `OFS_PIPE_CFG, {16'h0, cv & `CFG_MASK});
		rc("ctrl kept", `OFS_PIPE_CTRL_BASE + 16'hc, 32'h0);
		wr(`OFS_PIPE_CTRL_BASE + 16'hc, 32'h0000fe01);
		wr(`OFS_WINDOW_SELECT, 32'h4);
		rc("ctrl direct", `OFS_PIPE_CTRL_BASE + 16'hc, 32'h201);
		pls(0, 4'h8);
		rc("busy set", `OFS_PIPE_CTRL_BASE + 16'hc, 32'h221);
		pls(1, 4'h8);
		rc("busy clr", `OFS_PIPE_CTRL_BASE + 16'hc, 32'h201);
		$display("test control done");
		wr(`OFS_PIPE_CFG, 32'h4084);
		wr(`OFS_PIPE_CTRL_BASE, 32'h1);
		pls(2, 4'h1);
		rc("nak short", `OFS_PIPE_CTRL_BASE, 32'h0);
		chk("resp4", 32'h0, {30'h0, resp_code_q[1:0]});
		wr(`OFS_PIPE_CTRL_BASE, 32'h1);
		pls(3, 4'h1);
		rc("nak count", `OFS_PIPE_CTRL_BASE, 32'h0);
		wr(`OFS_PIPE_CTRL_BASE + 16'h4, 32'h1);
		pls(2, 4'h2);
		rc("tx no nak", `OFS_PIPE_CTRL_BASE + 16'h4, 32'h1);
		chk("resp5", 32'h1, {30'h0, resp_code_q[3:2]});
		$display("test auto nak done");
		wr(`OFS_PIPE_CFG, 32'h4484);
		b0 = rdy0;
		pls(4, 4'h1);
		repeat (3) @(posedge core_clk);
		chk("ready rx", 32'h1, 32'(rdy0 - b0));
		chk("blocked", 32'h1, {28'h0, rx_blocked_q});
		rc("event blk", `OFS_PIPE_EVENT, 32'h1);
		wr(`OFS_PIPE_EVENT, 32'h0410);
		rc("event clr", `OFS_PIPE_EVENT, 32'h0);
		b1 = rdy1;
		pls(5, 4'h2);
		pls(4, 4'h2);
		repeat (3) @(posedge core_clk);
		chk("ready tx", 32'h0, 32'(rdy1 - b1));
		acc(1'b0, 16'h2f00, 32'h0);
		chk("unmapped", 32'h2, {30'h0, got_r});
		$display("test ready done");
		test_done();
	end
endmodule // usb_pipe_window_config_test
